// ### hdl/eeprom_host_pkg.sv
package eeprom_host_pkg;

	localparam int ADDR_W     = 15;
	localparam int DATA_W     = 8;
	localparam int IDX_W      = 6;
	localparam int PAGE_BYTES = 64;
	localparam int CNT_W      = 20;

	localparam int CLK_NS     = 10;
	localparam int SYNC_CYC   = 3;
	localparam int WP_NS      = 100;
	localparam int WPH_NS     = 50;
	localparam int RD_NS      = 90;
	localparam int DF_NS      = 40;
	localparam int WC_US      = 3000;
	localparam int BLC_US     = 150;
	localparam int POWER_US   = 5000;

	localparam int WP_CYC     = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC    = (WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC     = (RD_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int DF_CYC     = (DF_NS + CLK_NS - 1) / CLK_NS;
	localparam int WC_CYC     = WC_US * 1000 / CLK_NS;
	localparam int BLC_CYC    = BLC_US * 1000 / CLK_NS;
	localparam int POWER_CYC  = (POWER_US * 1000 + CLK_NS - 1) / CLK_NS;

	localparam logic [ADDR_W-1:0] ID_BASE = 15'h7fc0;
	localparam int TOGGLE_BIT = 6;

	// Lock command sequence, arbitrary neutral values
	localparam logic [2:0][ADDR_W-1:0] LOCK_ADDR    = {15'h3333, 15'h2222, 15'h1111};
	localparam logic [2:0][DATA_W-1:0] LOCK_ON_DATA = {8'h33, 8'h22, 8'h11};
	localparam logic [2:0][DATA_W-1:0] LOCK_OFF_DATA = {8'h66, 8'h55, 8'h44};

	typedef enum logic [2:0] {
		OP_READ, OP_WRITE, OP_WRITE_GUARDED, OP_LOCK_ON, OP_LOCK_OFF
	} op_t;

	typedef struct packed {
		op_t               op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              id_area;
		logic              last;
	} cmd_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
		logic              timeout;
	} resp_t;

	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              id_hv;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe;
	} pins_t;

endpackage

// ### hdl/eeprom_host.sv
// Operation
// R1: Device drives stored byte during reads.
// R2: Device floats data when deselected.
// R3: Write: strobe low, select low, drive high.
// R4: Device latches address on later falling edge.
// R5: Device latches data on first rising edge.
// R6: Device self-times; reads poll meanwhile.
// R7: Programming period at most three milliseconds.
// R8: Page holds one to 64 bytes.
// R9: Next byte within load window, else programs.
// R10: Page bits constant through page load.
// R11: Low bits pick byte, any order.
// R12: Polling read returns inverted top bit.
// R13: After write, true data; new write allowed.
// R14: Toggle line flips each read while busy.
// R15: No write while drive low or deselected.
// R16: Very short strobe pulses are ignored.
// R17: Writes wait five milliseconds after power-up.
// R18: Three-byte sequence turns lock on.
// R19: Locked writes need the sequence first.
// R20: Lock survives power; cleared by disable sequence.
// R21: Sequences use page timing, store nothing.
// R22: Unguarded locked write only runs timer.
// R23: Raised select pin maps identification area.
module eeprom_host
	import eeprom_host_pkg::*;
#(
	parameter int WC_CYCLES    = WC_CYC,
	parameter int BLC_CYCLES   = BLC_CYC,
	parameter int POWER_CYCLES = POWER_CYC
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	input  wire logic              cmd_valid,
	input  wire cmd_t              cmd,
	output logic                   cmd_ready,
	output resp_t                  resp,
	output logic                   busy,
	output pins_t                  pins,
	input  wire logic [DATA_W-1:0] dq_in
);

	typedef enum logic [3:0] {
		S_POWER, S_IDLE, S_RD, S_REC, S_WR_SETUP, S_WR_LOW, S_WR_HIGH, S_GAP
	} state_t;

	state_t              state_q;
	cmd_t                cmd_q;
	pins_t               pins_q;
	resp_t               resp_q;
	logic                ready_q;
	logic                busy_q;
	logic [CNT_W-1:0]    cnt_q;
	logic [CNT_W-1:0]    wc_q;
	logic [1:0]          seq_q;
	logic                prefix_q;
	logic                polling_q;
	logic                have_prev_q;
	logic                prev_bit_q;
	logic [ADDR_W-IDX_W-1:0] page_q;
	logic                page_open_q;
	logic [IDX_W:0]      bytes_q;
	logic [DATA_W-1:0]   dq_s1_q, dq_s2_q, dq_s3_q, dq_stable_q;
	logic [ADDR_W-1:0]   wr_addr;
	logic [DATA_W-1:0]   wr_data;
	logic                take;
	logic                poll_done;

	assign cmd_ready = ready_q;
	assign resp      = resp_q;
	assign busy      = busy_q;
	assign pins      = pins_q;
	assign take      = cmd_valid && ready_q;

	// Data input synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_s1_q     <= 8'h00;
			dq_s2_q     <= 8'h00;
			dq_s3_q     <= 8'h00;
			dq_stable_q <= 8'h00;
		end else if (clk_en) begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
			dq_s3_q <= dq_s2_q;
			if (dq_s2_q == dq_s3_q)
				dq_stable_q <= dq_s3_q;
		end
	end

	// Byte for the current write step: lock sequence or user data
	always_comb begin
		wr_addr = cmd_q.addr;
		wr_data = cmd_q.data;
		if (prefix_q) begin
			wr_addr = LOCK_ADDR[seq_q]; // R19
			wr_data = (cmd_q.op == OP_LOCK_OFF) ? LOCK_OFF_DATA[seq_q]
				: LOCK_ON_DATA[seq_q]; // R18
		end else begin
			if (page_open_q)
				wr_addr = {page_q, cmd_q.addr[IDX_W-1:0]}; // R10 R11
			if (cmd_q.id_area)
				wr_addr = ID_BASE | {9'h000, wr_addr[IDX_W-1:0]}; // R23
		end
	end

	// Toggle line stopped: two polling reads in a row agree
	assign poll_done = have_prev_q && (dq_stable_q[TOGGLE_BIT] == prev_bit_q); // R14

	// Main sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= S_POWER;
			cmd_q       <= '0;
			pins_q      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, id_hv: 1'b0,
				addr: 15'h0000, dq_out: 8'h00, dq_oe: 1'b0};
			resp_q      <= '0;
			ready_q     <= 1'b0;
			busy_q      <= 1'b1;
			cnt_q       <= '0;
			seq_q       <= 2'h0;
			prefix_q    <= 1'b0;
			polling_q   <= 1'b0;
			have_prev_q <= 1'b0;
			prev_bit_q  <= 1'b0;
			page_q      <= '0;
			page_open_q <= 1'b0;
			bytes_q     <= '0;
		end else if (clk_en) begin
			resp_q.valid <= 1'b0;
			cnt_q        <= cnt_q + 1'b1;
			unique case (state_q)
				S_POWER: begin
					if (cnt_q == CNT_W'(POWER_CYCLES - 1)) begin // R17
						state_q <= S_IDLE;
						ready_q <= 1'b1;
						busy_q  <= 1'b0;
					end
				end
				S_IDLE: begin
					cnt_q <= '0;
					if (take) begin
						cmd_q       <= cmd;
						ready_q     <= 1'b0;
						busy_q      <= 1'b1;
						seq_q       <= 2'h0;
						prefix_q    <= (cmd.op != OP_WRITE) && (cmd.op != OP_READ); // R19
						page_open_q <= 1'b0;
						bytes_q     <= '0;
						pins_q.id_hv <= cmd.id_area; // R23
						state_q     <= (cmd.op == OP_READ) ? S_RD : S_WR_SETUP;
					end
				end
				S_RD: begin
					pins_q.addr <= cmd_q.id_area
						? (ID_BASE | {9'h000, cmd_q.addr[IDX_W-1:0]}) : cmd_q.addr;
					if (polling_q)
						pins_q.addr <= wr_addr;
					pins_q.ce_n <= 1'b0;
					pins_q.oe_n <= 1'b0;
					if (cnt_q == CNT_W'(RD_CYC)) begin
						pins_q.ce_n <= 1'b1;
						pins_q.oe_n <= 1'b1;
						cnt_q       <= '0;
						state_q     <= S_REC;
					end
				end
				S_REC: begin
					if (cnt_q == CNT_W'(DF_CYC - 1)) begin
						cnt_q <= '0;
						if (!polling_q) begin
							resp_q  <= '{valid: 1'b1, data: dq_stable_q, timeout: 1'b0};
							state_q <= S_IDLE;
							ready_q <= 1'b1;
							busy_q  <= 1'b0;
							pins_q.id_hv <= 1'b0;
						end else if (poll_done || wc_q >= CNT_W'(WC_CYCLES)) begin // R6 R7 R13
							resp_q  <= '{valid: 1'b1, data: dq_stable_q, timeout: !poll_done};
							polling_q <= 1'b0;
							state_q <= S_IDLE;
							ready_q <= 1'b1;
							busy_q  <= 1'b0;
							pins_q.id_hv <= 1'b0;
						end else begin
							have_prev_q <= 1'b1;
							prev_bit_q  <= dq_stable_q[TOGGLE_BIT];
							state_q     <= S_RD;
						end
					end
				end
				S_WR_SETUP: begin
					ready_q       <= 1'b0;
					pins_q.addr   <= wr_addr;
					pins_q.dq_out <= wr_data;
					pins_q.dq_oe  <= 1'b1;
					pins_q.oe_n   <= 1'b1; // R3 R15
					pins_q.ce_n   <= 1'b0;
					state_q       <= S_WR_LOW;
					cnt_q         <= '0;
					if (!prefix_q && !page_open_q) begin
						page_q      <= wr_addr[ADDR_W-1:IDX_W]; // R10
						page_open_q <= 1'b1;
					end
				end
				S_WR_LOW: begin
					pins_q.we_n <= 1'b0; // R3
					if (cnt_q == CNT_W'(WP_CYC)) begin // R16
						pins_q.we_n <= 1'b1;
						cnt_q       <= '0;
						state_q     <= S_WR_HIGH;
					end
				end
				S_WR_HIGH: begin
					if (cnt_q == CNT_W'(WPH_CYC - 1)) begin
						pins_q.ce_n  <= 1'b1;
						pins_q.dq_oe <= 1'b0;
						cnt_q        <= '0;
						if (prefix_q && seq_q != 2'h2) begin
							seq_q   <= seq_q + 2'h1; // R21
							state_q <= S_WR_SETUP;
						end else if (prefix_q && cmd_q.op != OP_WRITE_GUARDED) begin
							prefix_q <= 1'b0; // R18
							polling_q <= 1'b1;
							have_prev_q <= 1'b0;
							state_q  <= S_RD;
						end else if (prefix_q) begin
							prefix_q <= 1'b0;
							state_q  <= S_WR_SETUP;
						end else begin
							bytes_q <= bytes_q + 1'b1;
							if (cmd_q.last || bytes_q == 7'(PAGE_BYTES - 1)) begin // R8
								polling_q   <= 1'b1;
								have_prev_q <= 1'b0;
								state_q     <= S_RD;
							end else begin
								ready_q <= 1'b1;
								state_q <= S_GAP;
							end
						end
					end
				end
				S_GAP: begin
					if (take) begin
						cmd_q.addr <= cmd.addr;
						cmd_q.data <= cmd.data;
						cmd_q.last <= cmd.last;
						ready_q    <= 1'b0;
						state_q    <= S_WR_SETUP;
					end else if (cnt_q >= CNT_W'(BLC_CYCLES - 2)) begin // R9
						ready_q     <= 1'b0;
						polling_q   <= 1'b1;
						have_prev_q <= 1'b0;
						cnt_q       <= '0;
						state_q     <= S_RD;
					end
				end
			endcase
		end
	end

	// Elapsed programming time, from the last strobe of a load
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			wc_q <= '0;
		else if (clk_en) begin
			if (state_q == S_WR_LOW)
				wc_q <= '0;
			else if (wc_q != '1)
				wc_q <= wc_q + 1'b1; // R7
		end
	end

	chk_write_drive_high: assert property (@(posedge clk) disable iff (!reset_n) // R3
		!pins_q.we_n |-> pins_q.oe_n && !pins_q.ce_n)
		else $error("strobe low without select low and drive high");
	chk_no_contention: assert property (@(posedge clk) disable iff (!reset_n) // R2
		pins_q.dq_oe |-> pins_q.oe_n)
		else $error("host drives data while output drive low");
	chk_pulse_width: assert property (@(posedge clk) disable iff (!reset_n) // R16
		(clk_en && $fell(pins_q.we_n)) |-> !pins_q.we_n [*8])
		else $error("write strobe pulse too short");
	chk_power_wait: assert property (@(posedge clk) disable iff (!reset_n) // R17
		state_q == S_POWER |-> pins_q.we_n && busy_q)
		else $error("write attempted before power-up delay");
	chk_page_bits: assert property (@(posedge clk) disable iff (!reset_n) // R10
		($fell(pins_q.we_n) && !prefix_q && bytes_q != '0)
			|-> pins_q.addr[ADDR_W-1:IDX_W] == page_q)
		else $error("page bits changed during page load");
	chk_gap_window: assert property (@(posedge clk) disable iff (!reset_n) // R9
		state_q == S_GAP |-> cnt_q < CNT_W'(BLC_CYCLES))
		else $error("byte load window exceeded");
	chk_byte_count: assert property (@(posedge clk) disable iff (!reset_n) // R8
		bytes_q <= 7'(PAGE_BYTES))
		else $error("more than one page of bytes loaded");
	chk_lock_address: assert property (@(posedge clk) disable iff (!reset_n) // R19 R21
		($fell(pins_q.we_n) && prefix_q) |-> pins_q.addr == LOCK_ADDR[seq_q])
		else $error("lock sequence address wrong");
	chk_poll_ends: assert property (@(posedge clk) disable iff (!reset_n) // R6 R14
		(state_q == S_REC && polling_q && clk_en && cnt_q == CNT_W'(DF_CYC - 1) && poll_done)
			|=> resp_q.valid && !resp_q.timeout && ready_q)
		else $error("polling did not end on stopped toggle");
	chk_busy_ready: assert property (@(posedge clk) disable iff (!reset_n) // R13
		ready_q && state_q == S_IDLE |-> !busy_q && !polling_q)
		else $error("ready while write cycle pending");

	cov_read: cover property (@(posedge clk) disable iff (!reset_n)
		resp_q.valid && !polling_q && !resp_q.timeout);
	cov_page: cover property (@(posedge clk) disable iff (!reset_n) bytes_q == 7'h02);
	cov_lock_on: cover property (@(posedge clk) disable iff (!reset_n)
		prefix_q && seq_q == 2'h2 && cmd_q.op == OP_LOCK_ON);
	cov_timeout: cover property (@(posedge clk) disable iff (!reset_n)
		resp_q.valid && resp_q.timeout);

endmodule

// ### test/eeprom_model.sv
module eeprom_model
	import eeprom_host_pkg::*;
#(
	parameter int WC_M    = 100,
	parameter int BLC_M   = 30,
	parameter int POWER_M = 10
) (
	input  wire logic         clk,
	input  wire pins_t        pins,
	output logic [DATA_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic              hv;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
	} load_ent_t;
	logic [DATA_W-1:0] mem [0:32767];
	logic [DATA_W-1:0] idm [0:63];
	load_ent_t         q [$];
	logic [DATA_W-1:0] last_d = 8'hff;
	logic [DATA_W-1:0] dq_hold = 8'h00;
	logic              tog = 1'b0;
	logic              lock = 1'b0;
	logic              lock_pend = 1'b0;
	int                prog = 0;
	int                gap = 0;
	int                up = 0;
	realtime           t0;
	logic              hv_q;
	logic [ADDR_W-1:0] a_q;
	wire               wr = !pins.ce_n && !pins.we_n && pins.oe_n;
	wire               rd = !pins.ce_n && !pins.oe_n && pins.we_n;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		foreach (idm[i]) idm[i] = 8'hff;
	end
	task automatic close_load;
		int k;
		logic on;
		logic off;
		k = 0;
		on = q.size() >= 3;
		off = on;
		for (int i = 0; i < 3 && i < q.size(); i++) begin
			on &= q[i].a == LOCK_ADDR[i] && q[i].d == LOCK_ON_DATA[i];
			off &= q[i].a == LOCK_ADDR[i] && q[i].d == LOCK_OFF_DATA[i];
		end
		if (on || off) k = 3;
		else if (lock) k = q.size();
		if (on) lock_pend = 1'b1;
		if (off) lock = 1'b0;
		for (int i = k; i < q.size(); i++) begin
			if (q[i].hv && q[i].a >= ID_BASE) idm[q[i].a[5:0]] = q[i].d;
			else mem[q[i].a] = q[i].d;
		end
		last_d = q[q.size()-1].d;
		prog = WC_M;
		gap = 0;
		q.delete();
	endtask
	always @(posedge wr) begin
		t0 = $realtime;
		a_q = pins.addr;
		hv_q = pins.id_hv;
	end
	always @(negedge wr) begin
		if ($realtime - t0 >= 15.0 && up >= POWER_M && prog == 0) begin
			q.push_back('{hv_q, a_q, pins.dq_out});
			gap = 0;
			if (q.size() == PAGE_BYTES) close_load();
		end
	end
	// A read ends an open byte load
	always @(posedge rd) if (q.size() > 0) close_load();
	// Released bus shows the inverse of the byte last driven during a read
	always @(posedge clk) if (rd) dq_hold <= dq_in;
	always @(negedge rd) if (prog > 0) tog = ~tog;
	always @(posedge clk) begin
		up++;
		if (q.size() > 0) gap++;
		if (gap >= BLC_M) close_load();
		if (prog > 0) prog--;
		if (prog == 0 && lock_pend) begin
			lock = 1'b1;
			lock_pend = 1'b0;
		end
	end
	always @* begin
		if (!rd) dq_in = ~dq_hold;
		else if (prog > 0) dq_in = {~last_d[7], tog, last_d[5:0]};
		else if (pins.id_hv && pins.addr >= ID_BASE) dq_in = idm[pins.addr[5:0]];
		else dq_in = mem[pins.addr];
	end
endmodule

// ### test/tb_eeprom_host.sv
module tb_eeprom_host;
	import eeprom_host_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              cmd_valid = 1'b0;
	cmd_t              cmd = '0;
	resp_t             resp;
	logic              cmd_ready;
	logic              busy;
	pins_t             pins;
	logic [DATA_W-1:0] dq_in;
	int                n_fail = 0;
	int                tests_run = 0;
	logic              clk_en = 1'b1;
	always #5 clk = ~clk;
	eeprom_host #(.WC_CYCLES(200), .BLC_CYCLES(40), .POWER_CYCLES(20)) dut (
		.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .resp(resp), .busy(busy), .pins(pins), .dq_in(dq_in));
	eeprom_model model (
		.clk(clk), .pins(pins), .dq_in(dq_in));
	task final_report;
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("ERROR %s expected %h got %h", what, e, g);
			n_fail++;
		end
	endtask
	task hang(input string what);
		$display("ERROR %s expected 1 got timeout", what);
		n_fail++;
		final_report();
	endtask
	task send(input op_t op, input logic [14:0] a, input logic [7:0] d, input logic id, last);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = '{op, a, d, id, last};
		for (int i = 0; i < 5000 && cmd_ready !== 1'b1; i++) @(negedge clk);
		if (cmd_ready !== 1'b1) hang("cmd_ready");
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask
	task get(output logic [7:0] d);
		for (int i = 0; i < 5000 && resp.valid !== 1'b1; i++) @(negedge clk);
		if (resp.valid !== 1'b1) hang("resp.valid");
		d = resp.data;
		chk("resp.timeout", 8'h00, {7'h00, resp.timeout});
	endtask
	task wr(input op_t op, input logic [14:0] a, input logic [7:0] d, input logic id, last);
		logic [7:0] r;
		send(op, a, d, id, last);
		if (last) get(r);
	endtask
	task read_chk(input logic [14:0] a, input logic id, input logic [7:0] e, input string w);
		logic [7:0] r;
		send(OP_READ, a, 8'h00, id, 1'b1);
		get(r);
		chk(w, e, r);
	endtask
	always @(posedge clk) begin
		if (reset_n && pins.we_n === 1'b0 && pins.oe_n !== 1'b1) begin
			$display("ERROR oe_n expected 1 got %b", pins.oe_n);
			n_fail++;
		end
	end
	task t_byte;
		wr(OP_WRITE, 15'h0105, 8'ha5, 1'b0, 1'b1);
		read_chk(15'h0105, 1'b0, 8'ha5, "byte_a5");
		wr(OP_WRITE, 15'h0105, 8'h5a, 1'b0, 1'b1);
		read_chk(15'h0105, 1'b0, 8'h5a, "byte_5a");
	endtask
	// Clock enable low in mid-read: pins and status must hold still
	task t_freeze;
		logic [7:0] r;
		send(OP_READ, 15'h0105, 8'h00, 1'b0, 1'b1);
		repeat (3) @(negedge clk);
		clk_en = 1'b0;
		repeat (20) @(negedge clk);
		chk("frozen_ce_n", 8'h00, {7'h00, pins.ce_n});
		chk("frozen_busy", 8'h01, {7'h00, busy});
		clk_en = 1'b1;
		get(r);
		chk("freeze_read", 8'h5a, r);
	endtask
	task t_page;
		wr(OP_WRITE, 15'h0205, 8'h11, 1'b0, 1'b0);
		wr(OP_WRITE, 15'h0202, 8'h22, 1'b0, 1'b0);
		wr(OP_WRITE, 15'h0205, 8'h33, 1'b0, 1'b0);
		wr(OP_WRITE, 15'h023f, 8'h44, 1'b0, 1'b1);
		read_chk(15'h0205, 1'b0, 8'h33, "page_over");
		read_chk(15'h0202, 1'b0, 8'h22, "page_low");
		read_chk(15'h023f, 1'b0, 8'h44, "page_top");
		read_chk(15'h0203, 1'b0, 8'hff, "page_skip");
	endtask
	task t_gap;
		logic [7:0] r;
		send(OP_WRITE, 15'h0400, 8'h66, 1'b0, 1'b0);
		get(r);
		read_chk(15'h0400, 1'b0, 8'h66, "gap_close");
	endtask
	task t_lock;
		wr(OP_LOCK_ON, 15'h0000, 8'h00, 1'b0, 1'b1);
		wr(OP_WRITE, 15'h0300, 8'h12, 1'b0, 1'b1);
		read_chk(15'h0300, 1'b0, 8'hff, "locked_plain");
		wr(OP_WRITE_GUARDED, 15'h0300, 8'h77, 1'b0, 1'b1);
		read_chk(15'h0300, 1'b0, 8'h77, "locked_guard");
		read_chk(LOCK_ADDR[0], 1'b0, 8'hff, "seq_not_kept");
		wr(OP_LOCK_OFF, 15'h0000, 8'h00, 1'b0, 1'b1);
		wr(OP_WRITE, 15'h0301, 8'h99, 1'b0, 1'b1);
		read_chk(15'h0301, 1'b0, 8'h99, "unlocked");
	endtask
	task t_id;
		wr(OP_WRITE, 15'h0003, 8'hc3, 1'b1, 1'b1);
		read_chk(15'h0003, 1'b1, 8'hc3, "id_area");
		read_chk(15'h7fc3, 1'b0, 8'hff, "main_area");
	endtask
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		t_byte();
		t_freeze();
		t_page();
		t_gap();
		t_lock();
		t_id();
		final_report();
	end
endmodule
